/* design/status_reporting_error_queue.sv */
/*
 status registers, summary byte, error queue, offset clamp and version
 reply of the instrument status block.
 assumes all strobes are one-cycle pulses synchronous to clock_i and that
 reads are single cycle; read data is registered and valid one cycle later.
*/
`timescale 1ns/1ps
module status_reporting_error_queue
  import status_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int OFS_W = 16
)(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [QUES_W-1:0] ques_cond_i,
  input wire logic ques_event_read_i,
  input wire logic ques_cond_read_i,
  input wire logic ques_enable_write_i,
  input wire logic ques_enable_read_i,
  input wire logic [QUES_W-1:0] ques_enable_data_i,
  input wire logic preset_i,
  input wire logic clear_status_i,
  input wire logic [7:0] std_event_set_i,
  input wire logic std_event_read_i,
  input wire logic std_mask_write_i,
  input wire logic std_mask_read_i,
  input wire logic [7:0] std_mask_data_i,
  input wire logic summary_read_i,
  input wire logic operation_summary_i,
  input wire logic service_request_i,
  input wire logic message_available_i,
  input wire logic opc_command_i,
  input wire logic operation_done_i,
  input wire logic error_push_i,
  input wire logic [ERR_CODE_W-1:0] error_code_i,
  input wire logic [ERR_MSG_W-1:0] error_msg_i,
  input wire logic error_read_i,
  input wire logic offset_write_i,
  input wire logic [OFS_W-1:0] offset_request_i,
  input wire logic [OFS_W-1:0] offset_limit_i,
  input wire logic version_read_i,
  output logic [QUES_W-1:0] read_data_o,
  output logic read_valid_o,
  output logic [ERR_CODE_W-1:0] error_code_o,
  output logic [ERR_MSG_W-1:0] error_msg_o,
  output logic error_valid_o,
  output logic [7:0] summary_byte_o,
  output logic [OFS_W-1:0] offset_o,
  output logic [15:0] version_year_o,
  output logic [7:0] version_rev_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  // refused at elaboration: the pointer wrap needs at least two slots
  if (DEPTH < 2 || OFS_W < 1) begin : g_param_check
    $error("queue depth must be at least 2 and offset width at least 1");
  end

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // ************************************************************
  // questionable and standard event groups
  // ************************************************************
  logic [QUES_W-1:0] cond_q, event_q, event_d, enable_q;
  logic [7:0] std_event_q, std_event_d, std_mask_q;
  logic opc_pending_q;

  wire [QUES_W-1:0] cond_rise = ques_cond_i & ~cond_q; // RL16
  wire ques_summary = |(event_q & enable_q); // RL4
  wire std_summary = |(std_event_q & std_mask_q); // RL6
  wire opc_fire = opc_pending_q & operation_done_i; // RL17

  // set wins over the clearing read so no edge is lost
  assign event_d = (ques_event_read_i || clear_status_i) ? cond_rise : (event_q | cond_rise); // RL1 RL16
  assign std_event_d = ((std_event_read_i || clear_status_i) ? 8'h00 : std_event_q)
                       | std_event_set_i | (opc_fire ? 8'h01 << SE_OPC_BIT : 8'h00); // RL17

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cond_q <= QUES_RESET;
      event_q <= QUES_RESET;
      enable_q <= QUES_RESET;
      std_event_q <= BYTE_RESET;
      std_mask_q <= BYTE_RESET;
      opc_pending_q <= 1'b0;
    end else begin
      cond_q <= ques_cond_i;
      event_q <= event_d;
      std_event_q <= std_event_d;
      if (preset_i) begin
        enable_q <= QUES_RESET; // RL3
        std_mask_q <= BYTE_RESET; // RL3
      end else begin
        if (ques_enable_write_i) begin
          enable_q <= ques_enable_data_i;
        end
        if (std_mask_write_i) begin
          std_mask_q <= std_mask_data_i;
        end
      end
      if (opc_fire || clear_status_i) begin
        opc_pending_q <= 1'b0;
      end else if (opc_command_i) begin
        opc_pending_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // summary byte
  // ************************************************************
  logic [7:0] summary_d;
  always_comb begin
    summary_d = 8'h00;
    summary_d[SB_OPR_BIT] = operation_summary_i; // RL5
    summary_d[SB_RQS_BIT] = service_request_i;
    summary_d[SB_ESB_BIT] = std_summary;
    summary_d[SB_MAV_BIT] = message_available_i;
    summary_d[SB_QUE_BIT] = ques_summary; // RL4
  end

  // ************************************************************
  // register reads, plain binary is the weighted sum
  // ************************************************************
  wire [QUES_W-1:0] read_mux =
    ques_event_read_i ? event_q : // RL1 RL7
    ques_cond_read_i ? cond_q : // RL2
    ques_enable_read_i ? enable_q : // RL8
    std_event_read_i ? QUES_W'(std_event_q) :
    std_mask_read_i ? QUES_W'(std_mask_q) : // RL6
    QUES_W'(summary_d); // RL7
  wire any_read = ques_event_read_i | ques_cond_read_i | ques_enable_read_i | std_event_read_i
                  | std_mask_read_i | summary_read_i;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      read_data_o <= QUES_RESET;
      read_valid_o <= 1'b0;
      summary_byte_o <= BYTE_RESET;
    end else begin
      read_data_o <= any_read ? read_mux : read_data_o;
      read_valid_o <= any_read;
      summary_byte_o <= summary_d;
    end
  end

  // ************************************************************
  // offset clamp, reports its own conflict into the queue
  // ************************************************************
  wire offset_bad = offset_write_i && (offset_request_i > offset_limit_i);
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      offset_o <= '0;
    end else if (offset_write_i) begin
      offset_o <= offset_bad ? offset_limit_i : offset_request_i; // RL14
    end
  end

  // ************************************************************
  // error queue
  // ************************************************************
  logic [ERR_CODE_W-1:0] code_mem [DEPTH];
  logic [ERR_MSG_W-1:0] msg_mem [DEPTH];
  logic [PTR_W-1:0] rd_q, wr_q;
  logic [CNT_W-1:0] count_q;

  // a clamp conflict takes the push slot; the external error that cycle loses
  wire push_req = error_push_i | offset_bad; // RL9 RL14
  wire [ERR_CODE_W-1:0] push_code = offset_bad ? CODE_CONFLICT : error_code_i;
  wire [ERR_MSG_W-1:0] push_msg = offset_bad ? MSG_CONFLICT : error_msg_i;
  wire is_empty = (count_q == '0);
  wire do_pop = error_read_i && !is_empty; // RL11
  wire is_full = (count_q == CNT_W'(DEPTH));
  wire do_push = push_req && (!is_full || do_pop); // RL13
  wire is_last_free = (count_q == CNT_W'(DEPTH - 1)) && !do_pop;

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      code_mem[wr_q] <= is_last_free ? CODE_TOO_MANY : push_code; // RL9 RL13
      msg_mem[wr_q] <= is_last_free ? MSG_TOO_MANY : push_msg;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rd_q <= '0;
      wr_q <= '0;
      count_q <= '0;
    end else if (clear_status_i) begin
      rd_q <= '0; // RL12
      wr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_pop) begin
        rd_q <= ptr_inc(rd_q); // RL10
      end
      if (do_push) begin
        wr_q <= ptr_inc(wr_q);
      end
      count_q <= count_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      error_code_o <= CODE_NO_ERROR;
      error_msg_o <= MSG_NO_ERROR;
      error_valid_o <= 1'b0;
    end else begin
      error_valid_o <= error_read_i;
      if (error_read_i) begin
        error_code_o <= is_empty ? CODE_NO_ERROR : code_mem[rd_q]; // RL10 RL11
        error_msg_o <= is_empty ? MSG_NO_ERROR : msg_mem[rd_q];
      end
    end
  end

  // ************************************************************
  // version reply
  // ************************************************************
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      version_year_o <= 16'h0000;
      version_rev_o <= 8'h00;
    end else if (version_read_i) begin
      version_year_o <= VERSION_YEAR; // RL15
      version_rev_o <= VERSION_REV;
    end
  end

endmodule

/* design/status_pkg.sv */
/*
 holds the constants, field positions, reset values and error codes of the
 status reporting and error queue block.
 assumes a command parser outside that decodes queries and commands into
 one-cycle strobes on the clock_i domain.
*/
// Function
// RL1: reading the questionable event register returns its weighted value and clears it.
// RL2: reading the questionable condition register returns its current weighted value.
// RL3: preset zeroes every enable register and leaves summary, standard event and events alone; the code also zeroes the standard event mask.
// RL4: a questionable event reaches summary bit 3 only while its enable bit is set.
// RL5: summary byte holds operation in 7, service request in 6, event summary in 5, message in 4, questionable in 3.
// RL6: a readable mask selects standard event bits that are ORed into the event summary bit.
// RL7: every status read returns the sum of the binary weights of the set bits.
// RL8: the questionable enable register reads back its unmasked bits as a weighted number.
// RL9: each detected error pushes its number and message identifier into the queue; the code drops an external error pushed in the same cycle as a clamp conflict.
// RL10: each error query returns and removes the oldest entry, first in first out.
// RL11: a query on an empty queue returns code 0 with the no-error message and changes nothing.
// RL12: clear status empties the whole error queue at once.
// RL13: the queue holds 20 entries; on overflow the newest becomes -350 and later errors are dropped until a read.
// RL14: an offset invalid for the amplitude is clamped to the largest allowed value and logs -221.
// RL15: the version query returns a four-digit year, a dot and a revision number.
// RL16: a questionable event bit latches on a rising condition bit and holds until read or cleared.
// RL17: operation complete sets standard event bit 0 once the pending burst or sweep finishes.
package status_pkg;

  // ************************************************************
  // summary byte layout and standard event operation complete bit
  // ************************************************************
  localparam int SB_OPR_BIT = 7;
  localparam int SB_RQS_BIT = 6;
  localparam int SB_ESB_BIT = 5;
  localparam int SB_MAV_BIT = 4;
  localparam int SB_QUE_BIT = 3;
  localparam int SE_OPC_BIT = 0;

  // ************************************************************
  // widths, queue depth and reset values
  // ************************************************************
  localparam int QUES_W = 16;
  localparam int ERR_CODE_W = 16;
  localparam int ERR_MSG_W = 8;
  localparam int QUEUE_DEPTH = 20;
  localparam logic [QUES_W-1:0] QUES_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ************************************************************
  // error codes and message identifiers
  // ************************************************************
  localparam logic [ERR_CODE_W-1:0] CODE_NO_ERROR = 16'h0000;
  localparam logic [ERR_CODE_W-1:0] CODE_TOO_MANY = 16'hfea2;
  localparam logic [ERR_CODE_W-1:0] CODE_CONFLICT = 16'hff23;
  localparam logic [ERR_MSG_W-1:0] MSG_NO_ERROR = 8'h00;
  localparam logic [ERR_MSG_W-1:0] MSG_TOO_MANY = 8'h01;
  localparam logic [ERR_MSG_W-1:0] MSG_CONFLICT = 8'h02;

  // ************************************************************
  // version as year and revision
  // ************************************************************
  // arbitrary values, not tied to any published release
  localparam logic [15:0] VERSION_YEAR = 16'h07c7;
  localparam logic [7:0] VERSION_REV = 8'h00;

endpackage

/* bench/status_reporting_error_queue_asserts.sv */
/* concurrent checks on the ports of the status block.
   assumes it is bound to every status_reporting_error_queue instance. */
`timescale 1ns/1ps
module status_reporting_error_queue_asserts
  import status_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [QUES_W-1:0] ques_cond_i,
  input wire logic ques_event_read_i,
  input wire logic ques_cond_read_i,
  input wire logic ques_enable_read_i,
  input wire logic ques_enable_write_i,
  input wire logic std_event_read_i,
  input wire logic std_mask_read_i,
  input wire logic summary_read_i,
  input wire logic preset_i,
  input wire logic clear_status_i,
  input wire logic message_available_i,
  input wire logic error_push_i,
  input wire logic error_read_i,
  input wire logic offset_write_i,
  input wire logic version_read_i,
  input wire logic [QUES_W-1:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic [ERR_CODE_W-1:0] error_code_o,
  input wire logic [ERR_MSG_W-1:0] error_msg_o,
  input wire logic error_valid_o,
  input wire logic [7:0] summary_byte_o,
  input wire logic [15:0] version_year_o,
  input wire logic [7:0] version_rev_o
);
  // ****************************************
  // sequences and properties
  // ****************************************
  wire any_rd = |{ques_event_read_i, ques_cond_read_i, ques_enable_read_i,
    std_event_read_i, std_mask_read_i, summary_read_i};
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // read right after preset, no write in between that could refill the mask
  sequence preset_then_en_rd;
    (preset_i && !ques_enable_write_i) ##1
      (ques_enable_read_i && !ques_event_read_i && !ques_cond_read_i && !ques_enable_write_i);
  endsequence
  sequence clear_then_query;
    (clear_status_i && !error_push_i && !offset_write_i) ##1
      (error_read_i && !error_push_i && !offset_write_i);
  endsequence
  chk_read_valid_pulse: assert property (any_rd |=> read_valid_o)
    else $error("read valid missing after read strobe");
  chk_no_stray_valid: assert property (!any_rd |=> !read_valid_o)
    else $error("read valid without read strobe");
  chk_err_valid_pulse: assert property (error_read_i |=> error_valid_o)
    else $error("error valid missing after query");
  chk_err_no_stray: assert property (!error_read_i |=> !error_valid_o)
    else $error("error valid without query");
  chk_mav_bit_follows: assert property (message_available_i |=> summary_byte_o[SB_MAV_BIT])
    else $error("message bit of summary not set");
  chk_cond_read_value: assert property ((ques_cond_read_i && !ques_event_read_i && $stable(ques_cond_i))
    |=> read_data_o == $past(ques_cond_i)) else $error("condition read value wrong");
  chk_preset_enable_zero: assert property (preset_then_en_rd |=> read_data_o == 16'h0000)
    else $error("enable not zero after preset");
  chk_clear_empties_queue: assert property (clear_then_query |=>
    (error_code_o == CODE_NO_ERROR && error_msg_o == MSG_NO_ERROR)) else $error("queue not empty after clear");
  chk_version_reply: assert property (version_read_i |-> ##[1:2]
    (version_year_o == VERSION_YEAR && version_rev_o == VERSION_REV)) else $error("version reply wrong");
endmodule

bind status_reporting_error_queue status_reporting_error_queue_asserts chk (.*);

/* bench/testbench.sv */
/* self-checking bench for the status block.
   assumes default parameters; inputs change 1 ns after the rising edge. */
`timescale 1ns/1ps
module testbench;
  import status_pkg::*;
  logic clock_i = 1'h0;
  logic reset_i = 1'h1;
  logic [15:0] ques_cond_i = '0, ques_enable_data_i = '0, error_code_i = '0, offset_request_i = '0;
  logic [15:0] offset_limit_i = '0, read_data_o, error_code_o, offset_o, version_year_o;
  logic ques_enable_write_i = '0, preset_i = '0, clear_status_i = '0, std_mask_write_i = '0;
  logic operation_summary_i = '0, service_request_i = '0, message_available_i = '0, opc_command_i = '0;
  logic operation_done_i = '0, error_push_i = '0, error_read_i = '0, offset_write_i = '0;
  logic version_read_i = '0, read_valid_o, error_valid_o;
  logic [7:0] std_event_set_i = '0, std_mask_data_i = '0, error_msg_i = '0;
  logic [7:0] error_msg_o, summary_byte_o, version_rev_o;
  logic [5:0] rd_s = '0;
  wire ques_event_read_i, ques_cond_read_i, ques_enable_read_i, std_event_read_i, std_mask_read_i, summary_read_i;
  assign {summary_read_i, std_mask_read_i, std_event_read_i, ques_enable_read_i, ques_cond_read_i,
    ques_event_read_i} = rd_s;
  int n_fail = 0;
  int num_checks = 0;
  status_reporting_error_queue dut (.*);
  always #4 clock_i = ~clock_i;
  // ****************************************
  // access tasks
  // ****************************************
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // leaves s low without a trailing edge so a read may follow at once
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick;
    s = 1'h0;
  endtask
  task automatic rd(int k, logic [15:0] e);
    rd_s = 6'h01 << k;
    tick;
    rd_s = '0;
    cmp("read_valid", 16'h0001, {15'h0000, read_valid_o});
    cmp("read_data", e, read_data_o);
    tick;
  endtask
  task automatic erd(logic [15:0] c, logic [7:0] m);
    pulse(error_read_i);
    cmp("error_valid", 16'h0001, {15'h0000, error_valid_o});
    cmp("error_code", c, error_code_o);
    cmp("error_msg", {8'h00, m}, {8'h00, error_msg_o});
    tick;
  endtask
  task automatic push(logic [15:0] c);
    error_code_i = c;
    error_msg_i = c[7:0];
    pulse(error_push_i);
    tick;
  endtask
  task automatic conclude;
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge clock_i);
    #1 reset_i = 1'h0;
    ques_cond_i = 16'h0005;
    tick;
    tick;
    rd(1, 16'h0005);
    rd(0, 16'h0005);
    rd(0, 16'h0000);
    ques_cond_i = 16'h000d;
    ques_enable_data_i = 16'h0004;
    pulse(ques_enable_write_i);
    tick;
    cmp("summary", 16'h0000, {8'h00, summary_byte_o});
    ques_enable_data_i = 16'h0008;
    pulse(ques_enable_write_i);
    tick;
    tick;
    cmp("summary", 16'h0008, {8'h00, summary_byte_o});
    rd(2, 16'h0008);
    pulse(preset_i);
    rd(2, 16'h0000);
    rd(0, 16'h0008);
    operation_summary_i = 1'h1;
    service_request_i = 1'h1;
    message_available_i = 1'h1;
    tick;
    tick;
    cmp("summary", 16'h00d0, {8'h00, summary_byte_o});
    std_mask_data_i = 8'h04;
    pulse(std_mask_write_i);
    std_event_set_i = 8'h02;
    tick;
    std_event_set_i = '0;
    tick;
    cmp("summary", 16'h00d0, {8'h00, summary_byte_o});
    std_event_set_i = 8'h04;
    pulse(opc_command_i);
    std_event_set_i = '0;
    operation_done_i = 1'h1;
    tick;
    operation_done_i = 1'h0;
    tick;
    cmp("summary", 16'h00f0, {8'h00, summary_byte_o});
    rd(4, 16'h0004);
    rd(5, 16'h00f0);
    rd(3, 16'h0007);
    push(16'h0030);
    pulse(clear_status_i);
    erd(CODE_NO_ERROR, MSG_NO_ERROR);
    for (int i = 1; i <= QUEUE_DEPTH + 1; i++) begin
      push(16'(i));
    end
    for (int i = 1; i < QUEUE_DEPTH; i++) begin
      erd(16'(i), 8'(i));
    end
    erd(CODE_TOO_MANY, MSG_TOO_MANY);
    erd(CODE_NO_ERROR, MSG_NO_ERROR);
    erd(CODE_NO_ERROR, MSG_NO_ERROR);
    offset_limit_i = 16'h0064;
    offset_request_i = 16'h00c8;
    pulse(offset_write_i);
    tick;
    cmp("offset", 16'h0064, offset_o);
    erd(CODE_CONFLICT, MSG_CONFLICT);
    offset_request_i = 16'h0032;
    pulse(offset_write_i);
    tick;
    cmp("offset", 16'h0032, offset_o);
    erd(CODE_NO_ERROR, MSG_NO_ERROR);
    pulse(version_read_i);
    tick;
    cmp("version_year", VERSION_YEAR, version_year_o);
    cmp("version_rev", {8'h00, VERSION_REV}, {8'h00, version_rev_o});
    conclude;
  end
endmodule
